/* dtc_pin_model.sv */
// Model of the pins and the vectoring side of the interrupt controller.
// Assumes the bench calls its tasks from processes clocked by ref_clk.
`timescale 1ns/10ps
module dtc_pin_model (
    // Clock
    input wire logic ref_clk,
    // Pins and acknowledges
    output logic count_pin_zero,
    output logic count_pin_one,
    output logic ext_irq_pin_zero_n,
    output logic ext_irq_pin_one_n,
    output logic [3:0] ack
);
    // ----------------------------------------------------------------
    // Pin events
    // ----------------------------------------------------------------
    initial begin
        count_pin_zero = 1'b1;
        count_pin_one = 1'b1;
        ext_irq_pin_zero_n = 1'b1;
        ext_irq_pin_one_n = 1'b1;
        ack = 4'h0;
    end
    // Each level held two peripheral cycles so no sample misses it
    task automatic falls(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            count_pin_zero <= 1'b0;
            count_pin_one <= 1'b0;
            repeat (12) @(posedge ref_clk);
            count_pin_zero <= 1'b1;
            count_pin_one <= 1'b1;
            repeat (12) @(posedge ref_clk);
        end
    endtask : falls
    task automatic irq(input logic v);
        @(posedge ref_clk);
        ext_irq_pin_zero_n <= v;
        ext_irq_pin_one_n <= v;
    endtask : irq
    // One-cycle vectoring pulse: 0/1 timers, 2/3 external
    task automatic pulse(input int k);
        @(posedge ref_clk);
        ack[k] <= 1'b1;
        @(posedge ref_clk);
        ack <= 4'h0;
    endtask : pulse
endmodule : dtc_pin_model

/* dtc_pin_sync.sv */
// Two-flop synchroniser for the asynchronous count and interrupt pins.
// Assumes the pins are quiet levels; reset value set per bit by parameter.
`timescale 1ns/10ps
module dtc_pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_sync
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } dtc_sync_state_t;

    dtc_sync_state_t state;
    dtc_sync_state_t next_state;

    always_comb begin
        next_state.stage1 = pin_async;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= {RESET_VAL, RESET_VAL};
        end else begin
            state <= next_state;
        end
    end

    assign pin_sync = state.stage2;

endmodule : dtc_pin_sync

/* dtc_pkg.sv */
// Constants, register map and carrier types of the dual timer/counter.
// Assumes a 32-bit APB master and one 250 MHz clock for the whole block.
package dtc_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] REG_TIMER_CONTROL_IDX = 10'h088;
    localparam logic [9:0] REG_TIMER_MODE_SELECT_IDX = 10'h089;
    localparam logic [9:0] REG_TIMER_ZERO_LOW_IDX = 10'h08a;
    localparam logic [9:0] REG_TIMER_ONE_LOW_IDX = 10'h08b;
    localparam logic [9:0] REG_TIMER_ZERO_HIGH_IDX = 10'h08c;
    localparam logic [9:0] REG_TIMER_ONE_HIGH_IDX = 10'h08d;
    localparam logic [9:0] REG_IRQ_ENABLE_IDX = 10'h0a8;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OVERFLOW_FLAG_ONE_POS = 7;
    localparam int RUN_BIT_ONE_POS = 6;
    localparam int OVERFLOW_FLAG_ZERO_POS = 5;
    localparam int RUN_BIT_ZERO_POS = 4;
    localparam int EXT_IRQ_FLAG_ONE_POS = 3;
    localparam int EXT_IRQ_TYPE_ONE_POS = 2;
    localparam int EXT_IRQ_FLAG_ZERO_POS = 1;
    localparam int EXT_IRQ_TYPE_ZERO_POS = 0;
    localparam int PIN_GATING_ONE_POS = 7;
    localparam int COUNTER_SELECT_ONE_POS = 6;
    localparam int MODE_FIELD_ONE_LSB_POS = 4;
    localparam int PIN_GATING_ZERO_POS = 3;
    localparam int COUNTER_SELECT_ZERO_POS = 2;
    localparam int MODE_FIELD_ZERO_LSB_POS = 0;
    localparam int GLOBAL_IRQ_ENABLE_POS = 7;
    localparam int TIMER_ONE_IRQ_ENABLE_POS = 3;
    localparam int TIMER_ZERO_IRQ_ENABLE_POS = 1;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam int PERIPH_CLOCKS_PER_CYCLE = 6;
    localparam logic [2:0] DIV_LAST = 3'(PERIPH_CLOCKS_PER_CYCLE - 1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'b00,
        DTC_MODE_CASCADE = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dtc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dtc_apb_rsp_t;

    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } dtc_step_t;

    typedef struct packed {
        logic [7:0] timer_control;
        logic [7:0] timer_mode_select;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [7:0] irq_enable;
        logic [2:0] div;
        logic [1:0] count_sample;
        logic [1:0] irq_pin_prev;
        logic [31:0] rdata;
    } dtc_state_t;

endpackage : dtc_pkg

/* dtc_timer_top.sv */
// Two timer/counters with shared control and mode registers on APB.
// Assumes an APB3 master on ref_clk; pins are asynchronous to it.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module dtc_timer_top
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave
    input wire dtc_apb_req_t apb_req,
    output dtc_apb_rsp_t apb_rsp,
    // External count and interrupt pins
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ext_irq_pin_zero_n,
    input wire logic ext_irq_pin_one_n,
    // Vectoring acknowledges from the interrupt controller
    input wire logic vector_ack_timer_zero,
    input wire logic vector_ack_timer_one,
    input wire logic vector_ack_ext_zero,
    input wire logic vector_ack_ext_one,
    // Interrupt requests
    output logic timer_zero_irq,
    output logic timer_one_irq,
    output logic ext_irq_req_zero,
    output logic ext_irq_req_one
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [3:0] pins_sync;
    logic cnt_pin0;
    logic cnt_pin1;
    logic irq_pin0_n;
    logic irq_pin1_n;

    dtc_pin_sync #(
        .W(4),
        .RESET_VAL(4'hf)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_async({ext_irq_pin_one_n, ext_irq_pin_zero_n, count_pin_one, count_pin_zero}),
        .pin_sync(pins_sync)
    );

    assign cnt_pin0 = pins_sync[0];
    assign cnt_pin1 = pins_sync[1];
    assign irq_pin0_n = pins_sync[2];
    assign irq_pin1_n = pins_sync[3];

    dtc_state_t state;
    dtc_state_t next_state;

    // ----------------------------------------------------------------
    // Counting step for one timer
    // ----------------------------------------------------------------
    // Split mode reuses the reload path with a zero reload, which is a
    // plain 8-bit wrap; timer 1 in mode 3 falls to the hold default.
    function automatic dtc_step_t dtc_step(
        input logic [1:0] mode,
        input logic [7:0] tl,
        input logic [7:0] th,
        input logic inc
    );
        dtc_step_t r;
        r.tl = tl;
        r.th = th;
        r.ovf = 1'b0;
        if (inc) begin
            case (mode)
                DTC_MODE_PRESCALE: begin
                    r.tl = {tl[7:5], 5'(tl[4:0] + 5'h01)};
                    if (tl[4:0] == 5'h1f) begin
                        r.th = th + 8'h01;
                        r.ovf = (th == 8'hff);
                    end
                end
                DTC_MODE_CASCADE: begin
                    r.tl = tl + 8'h01;
                    if (tl == 8'hff) begin
                        r.th = th + 8'h01;
                        r.ovf = (th == 8'hff);
                    end
                end
                DTC_MODE_RELOAD: begin
                    if (tl == 8'hff) begin
                        r.tl = th;
                        r.ovf = 1'b1;
                    end else begin
                        r.tl = tl + 8'h01;
                    end
                end
                default: begin
                    r.tl = tl;
                end
            endcase
        end
        return r;
    endfunction : dtc_step

    // ----------------------------------------------------------------
    // Decode of control and mode fields
    // ----------------------------------------------------------------
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split0;
    logic run_bit_zero;
    logic run_bit_one;
    logic pin_gating_zero;
    logic pin_gating_one;
    logic counter_select_zero;
    logic counter_select_one;
    logic tick;
    logic edge0;
    logic edge1;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc_hi0;
    logic irq_fall0;
    logic irq_fall1;

    assign mode0 = state.timer_mode_select[MODE_FIELD_ZERO_LSB_POS +: 2];
    assign mode1 = state.timer_mode_select[MODE_FIELD_ONE_LSB_POS +: 2];
    assign split0 = (mode0 == DTC_MODE_SPLIT);
    assign run_bit_zero = state.timer_control[RUN_BIT_ZERO_POS];
    assign run_bit_one = state.timer_control[RUN_BIT_ONE_POS];
    assign pin_gating_zero = state.timer_mode_select[PIN_GATING_ZERO_POS];
    assign pin_gating_one = state.timer_mode_select[PIN_GATING_ONE_POS];
    assign counter_select_zero = state.timer_mode_select[COUNTER_SELECT_ZERO_POS];
    assign counter_select_one = state.timer_mode_select[COUNTER_SELECT_ONE_POS];

    // One peripheral cycle every six clocks
    assign tick = (state.div == DIV_LAST);

    // Count pins are looked at once per peripheral cycle only
    assign edge0 = tick && state.count_sample[0] && !cnt_pin0;
    assign edge1 = tick && state.count_sample[1] && !cnt_pin1;

    assign run0 = run_bit_zero && (!pin_gating_zero || irq_pin0_n);
    // With timer 0 split, the run bit belongs to the high byte of timer 0;
    // timer 1 then ignores its run bit and is stopped only through mode 3 or its pin gate.
    assign run1 = (split0 || run_bit_one) && (!pin_gating_one || irq_pin1_n);
    assign inc0 = run0 && (counter_select_zero ? edge0 : tick);
    assign inc1 = run1 && (counter_select_one ? edge1 : tick);
    assign inc_hi0 = split0 && run_bit_one && tick;

    assign irq_fall0 = state.irq_pin_prev[0] && !irq_pin0_n;
    assign irq_fall1 = state.irq_pin_prev[1] && !irq_pin1_n;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic access;
    logic setup;
    logic wr;
    logic [9:0] idx;
    logic aligned;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    assign access = apb_req.psel && apb_req.penable;
    assign setup = apb_req.psel && !apb_req.penable;
    assign idx = apb_req.paddr[11:2];
    assign aligned = (apb_req.paddr[1:0] == 2'b00);
    assign wr = access && apb_req.pwrite && mapped;
    assign wbyte = apb_req.pwdata[7:0];

    always_comb begin
        mapped = aligned;
        rd_byte = BYTE_RESET;
        case (idx)
            REG_TIMER_CONTROL_IDX: rd_byte = state.timer_control;
            REG_TIMER_MODE_SELECT_IDX: rd_byte = state.timer_mode_select;
            REG_TIMER_ZERO_LOW_IDX: rd_byte = state.tl0;
            REG_TIMER_ONE_LOW_IDX: rd_byte = state.tl1;
            REG_TIMER_ZERO_HIGH_IDX: rd_byte = state.th0;
            REG_TIMER_ONE_HIGH_IDX: rd_byte = state.th1;
            REG_IRQ_ENABLE_IDX: rd_byte = state.irq_enable;
            default: mapped = 1'b0;
        endcase
        if (!aligned) begin
            rd_byte = BYTE_RESET;
        end
    end

    // Zero wait states; read data captured in the setup cycle
    assign apb_rsp.pready = access;
    assign apb_rsp.pslverr = access && !mapped;
    assign apb_rsp.prdata = state.rdata;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    dtc_step_t step0;
    dtc_step_t step1;
    dtc_step_t step_hi0;
    logic ovf0;
    logic ovf1;

    always_comb begin
        step0 = dtc_step(split0 ? DTC_MODE_RELOAD : mode0, state.tl0,
                         split0 ? BYTE_RESET : state.th0, inc0);
        step_hi0 = dtc_step(DTC_MODE_RELOAD, state.th0, BYTE_RESET, inc_hi0);
        step1 = dtc_step(mode1, state.tl1, state.th1, inc1);
        ovf0 = step0.ovf;
        ovf1 = split0 ? step_hi0.ovf : step1.ovf;

        next_state = state;
        next_state.div = tick ? 3'h0 : 3'(state.div + 3'h1);
        if (tick) begin
            next_state.count_sample = {cnt_pin1, cnt_pin0};
        end
        next_state.irq_pin_prev = {irq_pin1_n, irq_pin0_n};
        next_state.rdata = setup ? {24'h00_0000, rd_byte} : WORD_RESET;

        next_state.tl0 = step0.tl;
        next_state.th0 = split0 ? step_hi0.tl : step0.th;
        next_state.tl1 = step1.tl;
        next_state.th1 = step1.th;

        // Software writes override counting in the same cycle
        if (wr) begin
            case (idx)
                REG_TIMER_CONTROL_IDX: next_state.timer_control = wbyte;
                REG_TIMER_MODE_SELECT_IDX: next_state.timer_mode_select = wbyte;
                REG_TIMER_ZERO_LOW_IDX: next_state.tl0 = wbyte;
                REG_TIMER_ONE_LOW_IDX: next_state.tl1 = wbyte;
                REG_TIMER_ZERO_HIGH_IDX: next_state.th0 = wbyte;
                REG_TIMER_ONE_HIGH_IDX: next_state.th1 = wbyte;
                REG_IRQ_ENABLE_IDX: next_state.irq_enable = wbyte;
                default: next_state.irq_enable = state.irq_enable;
            endcase
        end

        // Clear by vectoring, then hardware set wins
        if (vector_ack_timer_zero) begin
            next_state.timer_control[OVERFLOW_FLAG_ZERO_POS] = 1'b0;
        end
        if (vector_ack_timer_one) begin
            next_state.timer_control[OVERFLOW_FLAG_ONE_POS] = 1'b0;
        end
        if (ovf0) begin
            next_state.timer_control[OVERFLOW_FLAG_ZERO_POS] = 1'b1;
        end
        if (ovf1) begin
            next_state.timer_control[OVERFLOW_FLAG_ONE_POS] = 1'b1;
        end

        // Level mode: flag follows the pin, so the ack never clears it
        if (!state.timer_control[EXT_IRQ_TYPE_ZERO_POS]) begin
            next_state.timer_control[EXT_IRQ_FLAG_ZERO_POS] = !irq_pin0_n;
        end else begin
            if (vector_ack_ext_zero) begin
                next_state.timer_control[EXT_IRQ_FLAG_ZERO_POS] = 1'b0;
            end
            if (irq_fall0) begin
                next_state.timer_control[EXT_IRQ_FLAG_ZERO_POS] = 1'b1;
            end
        end
        if (!state.timer_control[EXT_IRQ_TYPE_ONE_POS]) begin
            next_state.timer_control[EXT_IRQ_FLAG_ONE_POS] = !irq_pin1_n;
        end else begin
            if (vector_ack_ext_one) begin
                next_state.timer_control[EXT_IRQ_FLAG_ONE_POS] = 1'b0;
            end
            if (irq_fall1) begin
                next_state.timer_control[EXT_IRQ_FLAG_ONE_POS] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests
    // ----------------------------------------------------------------
    logic global_en;

    assign global_en = state.irq_enable[GLOBAL_IRQ_ENABLE_POS];
    assign timer_zero_irq = global_en && state.irq_enable[TIMER_ZERO_IRQ_ENABLE_POS]
                            && state.timer_control[OVERFLOW_FLAG_ZERO_POS];
    assign timer_one_irq = global_en && state.irq_enable[TIMER_ONE_IRQ_ENABLE_POS]
                           && state.timer_control[OVERFLOW_FLAG_ONE_POS];
    assign ext_irq_req_zero = state.timer_control[EXT_IRQ_FLAG_ZERO_POS];
    assign ext_irq_req_one = state.timer_control[EXT_IRQ_FLAG_ONE_POS];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic wr_any;

    assign wr_any = access && apb_req.pwrite;

    default clocking dtc_cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    chk_tick_period: assert property (
        tick |=> !tick [*5] ##1 tick
    ) else $error("peripheral tick not every six clocks");

    chk_reload_copy: assert property (
        (mode1 == DTC_MODE_RELOAD && !split0 && inc1 && state.tl1 == 8'hff && !wr_any)
        |=> (state.tl1 == $past(state.th1) && state.th1 == $past(state.th1)
             && state.timer_control[OVERFLOW_FLAG_ONE_POS])
    ) else $error("auto-reload did not copy high byte");

    chk_split_high: assert property (
        (split0 && run_bit_one && tick && state.th0 == 8'hff && !wr_any)
        |=> (state.th0 == 8'h00 && state.timer_control[OVERFLOW_FLAG_ONE_POS])
    ) else $error("split high byte overflow missed");

    chk_halt_hold: assert property (
        (mode1 == DTC_MODE_SPLIT && !wr_any)
        |=> ($stable(state.tl1) && $stable(state.th1))
    ) else $error("timer 1 moved in halt mode");

    chk_prescale_carry: assert property (
        (mode0 == DTC_MODE_PRESCALE && inc0 && state.tl0[4:0] == 5'h1f && !wr_any)
        |=> (state.th0 == 8'($past(state.th0) + 8'h01) && state.tl0[4:0] == 5'h00
             && state.tl0[7:5] == $past(state.tl0[7:5]))
    ) else $error("13-bit prescaler carry wrong");

    chk_gate_stop: assert property (
        (pin_gating_zero && !irq_pin0_n && !wr_any)
        |=> ($stable(state.tl0) && (split0 || $stable(state.th0)))
    ) else $error("gated timer 0 counted with pin low");

    chk_count_edge: assert property (
        (counter_select_zero && run0 && mode0 == DTC_MODE_CASCADE && edge0
         && state.tl0 != 8'hff && !wr_any)
        |=> (state.tl0 == 8'($past(state.tl0) + 8'h01))
    ) else $error("count pin fall not counted");

    chk_ovf_ack: assert property (
        (vector_ack_timer_zero && !ovf0 && !wr_any)
        |=> !state.timer_control[OVERFLOW_FLAG_ZERO_POS]
    ) else $error("overflow flag not cleared by vectoring");

    chk_irq_gate: assert property (
        !global_en |-> (!timer_zero_irq && !timer_one_irq)
    ) else $error("timer request passed without global enable");

    chk_edge_flag: assert property (
        (state.timer_control[EXT_IRQ_TYPE_ZERO_POS] && irq_fall0 && !wr_any)
        |=> state.timer_control[EXT_IRQ_FLAG_ZERO_POS] [*1]
    ) else $error("falling edge did not set external flag");

    chk_reset_zero: assert property (
        $past(srst) |-> (state.timer_control == 8'h00 && state.timer_mode_select == 8'h00
                         && state.tl0 == 8'h00 && state.th1 == 8'h00)
    ) else $error("registers not zero after reset");

endmodule : dtc_timer_top

/* dtc_timer_top_tb.sv */
// Self-checking bench for the dual timer/counter.
// Assumes zero-wait APB and the pin model standing for the far side.
`timescale 1ns/10ps
module dtc_timer_top_tb
    import dtc_pkg::*;
;
    localparam logic [9:0] A_CTL = REG_TIMER_CONTROL_IDX;
    localparam logic [9:0] A_MOD = REG_TIMER_MODE_SELECT_IDX;
    localparam logic [9:0] A_TL0 = REG_TIMER_ZERO_LOW_IDX;
    localparam logic [9:0] A_TL1 = REG_TIMER_ONE_LOW_IDX;
    localparam logic [9:0] A_TH0 = REG_TIMER_ZERO_HIGH_IDX;
    localparam logic [9:0] A_TH1 = REG_TIMER_ONE_HIGH_IDX;
    localparam logic [9:0] A_IEN = REG_IRQ_ENABLE_IDX;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    dtc_apb_req_t req = '0;
    dtc_apb_rsp_t rsp;
    logic cp0, cp1, ip0, ip1, irq0, irq1, eirq0, eirq1, se;
    logic [3:0] ack;
    logic [7:0] r, a;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    dtc_timer_top u_dtc_timer_top (.ref_clk(ref_clk), .srst(srst), .apb_req(req),
        .apb_rsp(rsp), .count_pin_zero(cp0), .count_pin_one(cp1),
        .ext_irq_pin_zero_n(ip0), .ext_irq_pin_one_n(ip1),
        .vector_ack_timer_zero(ack[0]), .vector_ack_timer_one(ack[1]),
        .vector_ack_ext_zero(ack[2]), .vector_ack_ext_one(ack[3]),
        .timer_zero_irq(irq0), .timer_one_irq(irq1),
        .ext_irq_req_zero(eirq0), .ext_irq_req_one(eirq1));
    dtc_pin_model u_dtc_pin_model (.ref_clk(ref_clk), .count_pin_zero(cp0),
        .count_pin_one(cp1), .ext_irq_pin_zero_n(ip0), .ext_irq_pin_one_n(ip1),
        .ack(ack));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    initial forever #2 ref_clk = ~ref_clk;
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Request held until pready is seen high, idle cycle after
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h00_0000, d}};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        while (rsp.pready !== 1'b1) @(posedge ref_clk);
        r = rsp.prdata[7:0];
        se = rsp.pslverr;
        req <= '0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask : wr
    task automatic wait_val(input logic [9:0] i, input logic [7:0] m, input logic [7:0] v);
        int n = 0;
        do begin
            apb(1'b0, i, 8'h00);
            n++;
        end while (n < 300 && (r & m) !== v);
        chk(r & m, v);
    endtask : wait_val
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [9:0] map [6];
        map = '{A_CTL, A_MOD, A_TL0, A_TL1, A_TH0, A_TH1};
        foreach (map[k]) begin
            apb(1'b0, map[k], 8'h00);
            chk(r, 8'h00);
        end
        apb(1'b0, 10'h080, 8'h00);
        chk({7'h00, se}, 8'h01);
        wr(A_MOD, 8'ha5);
        apb(1'b0, A_MOD, 8'h00);
        chk(r, 8'ha5);
        wr(A_MOD, 8'h00);
    endtask : t_reset
    task automatic t_cascade;
        wr(A_TL0, 8'hff);
        wr(A_TH0, 8'hff);
        wr(A_MOD, 8'h01);
        wr(A_CTL, 8'h10);
        wait_val(A_CTL, 8'h20, 8'h20);
        apb(1'b0, A_TH0, 8'h00);
        chk(r, 8'h00);
        apb(1'b0, A_TL0, 8'h00);
        a = r;
        repeat (57) @(posedge ref_clk);
        apb(1'b0, A_TL0, 8'h00);
        chk(r - a, 8'h0a);
        wr(A_IEN, 8'h02);
        chk({7'h00, irq0}, 8'h00);
        wr(A_IEN, 8'h82);
        chk({7'h00, irq0}, 8'h01);
        u_dtc_pin_model.pulse(0);
        apb(1'b0, A_CTL, 8'h00);
        chk(r & 8'h20, 8'h00);
        chk({7'h00, irq0}, 8'h00);
        wr(A_CTL, 8'h00);
    endtask : t_cascade
    task automatic t_reload;
        wr(A_TH1, 8'hf0);
        wr(A_TL1, 8'hfe);
        wr(A_MOD, 8'h20);
        wr(A_CTL, 8'h40);
        wait_val(A_CTL, 8'h80, 8'h80);
        apb(1'b0, A_TL1, 8'h00);
        chk(r & 8'hf8, 8'hf0);
        wr(A_TH1, 8'h80);
        wr(A_IEN, 8'h88);
        chk({7'h00, irq1}, 8'h01);
        u_dtc_pin_model.pulse(1);
        wait_val(A_CTL, 8'h80, 8'h80);
        apb(1'b0, A_TL1, 8'h00);
        chk(r & 8'hf8, 8'h80);
        apb(1'b0, A_TH1, 8'h00);
        chk(r, 8'h80);
        wr(A_MOD, 8'h30);
        apb(1'b0, A_TL1, 8'h00);
        a = r;
        repeat (30) @(posedge ref_clk);
        apb(1'b0, A_TL1, 8'h00);
        chk(r, a);
        wr(A_CTL, 8'h00);
    endtask : t_reload
    task automatic t_split;
        wr(A_TH0, 8'hfe);
        wr(A_TL0, 8'hfe);
        wr(A_MOD, 8'h33);
        wr(A_CTL, 8'h40);
        wait_val(A_CTL, 8'h80, 8'h80);
        chk(r & 8'h20, 8'h00);
        apb(1'b0, A_TL0, 8'h00);
        chk(r, 8'hfe);
        wr(A_CTL, 8'h10);
        wait_val(A_CTL, 8'h20, 8'h20);
        chk(r & 8'h80, 8'h00);
        wr(A_CTL, 8'h00);
    endtask : t_split
    task automatic t_pins;
        wr(A_MOD, 8'h55);
        wr(A_TL0, 8'h00);
        wr(A_TL1, 8'h00);
        wr(A_CTL, 8'h50);
        u_dtc_pin_model.falls(3);
        apb(1'b0, A_TL0, 8'h00);
        chk(r, 8'h03);
        apb(1'b0, A_TL1, 8'h00);
        chk(r, 8'h03);
        wr(A_CTL, 8'h00);
        wr(A_MOD, 8'h09);
        wr(A_TL0, 8'h00);
        // Pin low before run, so no count slips in through the synchroniser
        u_dtc_pin_model.irq(1'b0);
        wr(A_CTL, 8'h10);
        repeat (30) @(posedge ref_clk);
        apb(1'b0, A_TL0, 8'h00);
        chk(r, 8'h00);
        chk({7'h00, eirq0}, 8'h01);
        chk({7'h00, eirq1}, 8'h01);
        u_dtc_pin_model.irq(1'b1);
        repeat (30) @(posedge ref_clk);
        chk({7'h00, eirq0}, 8'h00);
        chk({7'h00, eirq1}, 8'h00);
        apb(1'b0, A_TL0, 8'h00);
        chk({7'h00, r != 8'h00}, 8'h01);
        wr(A_CTL, 8'h05);
        u_dtc_pin_model.irq(1'b0);
        repeat (8) @(posedge ref_clk);
        u_dtc_pin_model.irq(1'b1);
        repeat (8) @(posedge ref_clk);
        chk({7'h00, eirq0}, 8'h01);
        chk({7'h00, eirq1}, 8'h01);
        u_dtc_pin_model.pulse(2);
        @(posedge ref_clk);
        chk({7'h00, eirq0}, 8'h00);
        chk({7'h00, eirq1}, 8'h01);
        u_dtc_pin_model.pulse(3);
        @(posedge ref_clk);
        chk({7'h00, eirq1}, 8'h00);
        wr(A_CTL, 8'h00);
    endtask : t_pins
    task automatic t_prescale;
        wr(A_MOD, 8'h00);
        wr(A_TL0, 8'hfe);
        wr(A_TH0, 8'h00);
        wr(A_TL1, 8'hfe);
        wr(A_TH1, 8'h00);
        wr(A_CTL, 8'h50);
        wait_val(A_TH1, 8'hff, 8'h01);
        apb(1'b0, A_TL1, 8'h00);
        chk(r & 8'h1e, 8'h00);
        apb(1'b0, A_TH0, 8'h00);
        chk(r, 8'h01);
    endtask : t_prescale
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_cascade();
        t_reload();
        t_split();
        t_pins();
        t_prescale();
        give_verdict();
    end
endmodule : dtc_timer_top_tb
